// file: sdram_cmd_state.sv
// command decode and per-bank state sequencing of a four-bank sdram
// assumes commands and the clock gate are synchronous to clk_sys
// Overview of operation
// RULE_01: command is decoded from strobes and chip select sampled at rising edge
// RULE_02: fixed three-bit encoding of no-op, halt, read, write, open, close, refresh, mode
// RULE_03: legality of a command is judged against the bank the bank bits address
// RULE_04: refresh with gate high auto refreshes; with gate falling enters self refresh
// RULE_05: all idle with gate low enters power down, input buffers disabled
// RULE_06: row active read or write starts burst, bit ten picks auto-close
// RULE_07: controller keeps minimum row-open time before closing a bank
// RULE_08: burst halt stops a plain burst at once, bank back to row active
// RULE_09: idle cycles during read burst let it end, then row active
// RULE_10: new read during read burst ends old burst and starts new one
// RULE_11: write during read burst ends the read and starts the write
// RULE_12: controller masks write data not meeting write-to-close delay
// RULE_13: idle cycles during plain write burst end it into write recovery
// RULE_14: auto-close read finishes then precharges; other commands illegal
// RULE_15: auto-close write recovers then precharges; other commands illegal
// RULE_16: precharging goes idle after close-to-open delay; close is no-op there
// RULE_17: write recovery goes row active after delay; read or write accepted
// RULE_18: auto-close recovery precharges after delay; halt no-op, rest illegal
// RULE_19: auto refresh back to idle after row cycle time; only idle cmds meanwhile
// RULE_20: controller keeps open-to-open delay between banks
// RULE_21: self refresh held while gate low; exit with idle cmd plus row cycle time
// RULE_22: power down held while gate low; gate rising returns to idle
// RULE_23: self refresh only from all idle; power down from all idle or row active
// RULE_24: otherwise gate falling suspends next cycle, rising resumes next cycle
// RULE_25: controller counts all row timing delays per bank
`timescale 1ns/1ps
module sdram_cmd_state
  import sdram_cmd_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  cke,
  input  wire logic                  cs_n,
  input  wire logic                  ras_n,
  input  wire logic                  cas_n,
  input  wire logic                  we_n,
  input  wire logic [1:0]            ba,
  input  wire logic [11:0]           addr,
  input  wire logic [31:0]           dq_in,
  output logic      [15:0]           bank_states,
  output logic      [2:0]            dev_mode,
  output logic                       illegal_cmd,
  output logic                       input_buf_en,
  output logic      [11:0]           mode_word,
  output logic                       store_ready,
  output logic                       beat_valid,
  input  wire logic                  beat_ready,
  output logic      [FIFO_WIDTH-1:0] beat_data
);
  bank_state_t st_reg   [NBANK];
  bank_state_t st_next  [NBANK];
  logic [3:0]  cnt_reg  [NBANK];
  logic [3:0]  cnt_next [NBANK];
  dev_mode_t   mode_reg;
  dev_mode_t   mode_next;
  logic [3:0]  dcnt_reg;
  logic [3:0]  dcnt_next;
  logic [7:0]  wcol_reg;
  logic [7:0]  wcol_next;
  logic [1:0]  wbank_reg;
  logic [1:0]  wbank_next;
  logic [11:0] mode_word_reg;
  logic [11:0] mode_word_next;
  logic        illegal_next;
  logic        buf_en_next;
  logic        cke_q_reg;
  logic        run;
  logic        all_idle;
  logic        rest_ok;
  logic        idle_cmd;
  logic [2:0]  cmd;
  logic        push;
  logic [7:0]  push_col;
  logic [1:0]  push_bank;

  function automatic bank_state_t follow_state(input bank_state_t s);
    case (s)
      BK_ACTIVATING, BK_WR_RECOV, BK_READ: follow_state = BK_ROW_ACTIVE;
      BK_READ_AC, BK_WR_RECOV_AC:          follow_state = BK_PRECHARGING;
      BK_WRITE:                            follow_state = BK_WR_RECOV;
      BK_WRITE_AC:                         follow_state = BK_WR_RECOV_AC;
      default:                             follow_state = BK_IDLE;
    endcase
  endfunction : follow_state

  function automatic logic [3:0] load_count(input bank_state_t s);
    case (s)
      BK_PRECHARGING: load_count = RP_CYC - 4'h1;
      BK_WR_RECOV,
      BK_WR_RECOV_AC: load_count = DPL_CYC - 4'h1;
      default:        load_count = 4'h0;
    endcase
  endfunction : load_count

  function automatic logic is_timed(input bank_state_t s);
    is_timed = (s != BK_IDLE) && (s != BK_ROW_ACTIVE);
  endfunction : is_timed

  function automatic logic is_plain_burst(input bank_state_t s);
    is_plain_burst = (s == BK_READ) || (s == BK_WRITE);
  endfunction : is_plain_burst

  assign cmd      = {ras_n, cas_n, we_n}; // [RULE_01] [RULE_02]
  assign idle_cmd = cs_n || (ras_n && cas_n);
  assign run      = (mode_reg == DEV_NORMAL);

  always_comb begin
    all_idle = 1'b1;
    rest_ok  = 1'b1;
    for (int i = 0; i < NBANK; i++) begin
      if (st_reg[i] != BK_IDLE) all_idle = 1'b0;
      if (st_next[i] != BK_IDLE && st_next[i] != BK_ROW_ACTIVE) rest_ok = 1'b0;
    end
  end

  // bank sequencing and command effects
  always_comb begin
    st_next        = st_reg;
    cnt_next       = cnt_reg;
    wcol_next      = wcol_reg;
    wbank_next     = wbank_reg;
    mode_word_next = mode_word_reg;
    illegal_next   = 1'b0;
    push           = 1'b0;
    push_col       = wcol_reg;
    push_bank      = wbank_reg;
    if (run) begin
      for (int i = 0; i < NBANK; i++) begin
        if (st_reg[i] == BK_WRITE || st_reg[i] == BK_WRITE_AC) begin
          push      = 1'b1;
          wcol_next = wcol_reg + 8'h01;
        end
        if (is_timed(st_reg[i])) begin
          if (cnt_reg[i] <= 4'h1) begin // [RULE_09] [RULE_13] [RULE_16] [RULE_17] [RULE_18]
            st_next[i]  = follow_state(st_reg[i]);
            cnt_next[i] = load_count(follow_state(st_reg[i]));
          end else begin
            cnt_next[i] = cnt_reg[i] - 4'h1;
          end
        end
      end
      if (!cs_n) begin
        case (cmd)
          CMD_READ, CMD_WRITE: begin
            case (st_reg[ba]) // [RULE_03]
              BK_ROW_ACTIVE, BK_READ, BK_WRITE, BK_WR_RECOV: begin // [RULE_06] [RULE_10] [RULE_11] [RULE_17]
                if (cmd == CMD_READ) begin
                  st_next[ba] = addr[AUTO_CLOSE_BIT] ? BK_READ_AC : BK_READ;
                end else begin
                  st_next[ba] = addr[AUTO_CLOSE_BIT] ? BK_WRITE_AC : BK_WRITE;
                  push        = 1'b1;
                  push_col    = addr[7:0];
                  push_bank   = ba;
                  wcol_next   = addr[7:0] + 8'h01;
                  wbank_next  = ba;
                end
                cnt_next[ba] = BL_CYC - 4'h1;
              end
              default: illegal_next = 1'b1; // [RULE_14] [RULE_15]
            endcase
          end
          CMD_HALT: begin
            for (int i = 0; i < NBANK; i++) begin
              if (is_plain_burst(st_reg[i])) begin // [RULE_08]
                st_next[i]  = BK_ROW_ACTIVE;
                cnt_next[i] = 4'h0;
                push        = 1'b0;
              end
            end
            case (st_reg[ba])
              BK_ACTIVATING, BK_PRECHARGING, BK_READ_AC,
              BK_WRITE_AC, BK_MODE_ACCESS: illegal_next = 1'b1;
              default: ;
            endcase
          end
          CMD_OPEN: begin
            if (st_reg[ba] == BK_IDLE) begin
              st_next[ba]  = BK_ACTIVATING;
              cnt_next[ba] = RCD_CYC - 4'h1;
            end else begin
              illegal_next = 1'b1;
            end
          end
          CMD_CLOSE: begin
            for (int i = 0; i < NBANK; i++) begin
              if (addr[AUTO_CLOSE_BIT] || ba == 2'(i)) begin
                case (st_reg[i])
                  BK_ROW_ACTIVE, BK_READ, BK_WRITE: begin
                    st_next[i]  = BK_PRECHARGING;
                    cnt_next[i] = RP_CYC - 4'h1;
                    if (st_reg[i] == BK_WRITE) push = 1'b0;
                  end
                  BK_IDLE, BK_PRECHARGING: ; // [RULE_16]
                  default: illegal_next = 1'b1;
                endcase
              end
            end
          end
          CMD_REF: begin
            if (!all_idle) begin
              illegal_next = 1'b1;
            end else if (cke) begin // [RULE_04] [RULE_19]
              for (int i = 0; i < NBANK; i++) begin
                st_next[i]  = BK_REFRESHING;
                cnt_next[i] = RC_CYC - 4'h1;
              end
            end
          end
          CMD_MODE: begin
            if (all_idle) begin
              mode_word_next = addr;
              for (int i = 0; i < NBANK; i++) begin
                st_next[i]  = BK_MODE_ACCESS;
                cnt_next[i] = RSC_CYC - 4'h1;
              end
            end else begin
              illegal_next = 1'b1;
            end
          end
          default: ;
        endcase
        if (cmd != CMD_NOP && cmd != CMD_HALT) begin
          for (int i = 0; i < NBANK; i++) begin
            if (st_reg[i] == BK_REFRESHING) illegal_next = 1'b1; // [RULE_19]
          end
        end
      end
    end
  end

  // clock gate handling
  logic illegal_gate;
  always_comb begin
    mode_next    = mode_reg;
    dcnt_next    = dcnt_reg;
    illegal_gate = 1'b0;
    case (mode_reg)
      DEV_NORMAL: begin
        if (!cke) begin
          if (all_idle && !cs_n && cmd == CMD_REF) begin
            mode_next = DEV_SELF_REFRESH; // [RULE_04] [RULE_23]
          end else if (rest_ok) begin
            mode_next = DEV_POWER_DOWN; // [RULE_05] [RULE_23]
          end else begin
            mode_next = DEV_SUSPEND; // [RULE_24]
          end
        end
      end
      DEV_SUSPEND, DEV_POWER_DOWN: begin
        if (cke) mode_next = DEV_NORMAL; // [RULE_22] [RULE_24]
      end
      DEV_SELF_REFRESH: begin
        if (cke) begin
          if (idle_cmd) begin // [RULE_21]
            mode_next = DEV_SELF_RECOV;
            dcnt_next = RC_CYC - 4'h1;
          end else begin
            illegal_gate = 1'b1;
          end
        end
      end
      DEV_SELF_RECOV: begin
        if (!cke || !idle_cmd) illegal_gate = 1'b1;
        if (dcnt_reg <= 4'h1) begin
          mode_next = DEV_NORMAL; // [RULE_21]
        end else begin
          dcnt_next = dcnt_reg - 4'h1;
        end
      end
      default: mode_next = DEV_NORMAL;
    endcase
    buf_en_next = (mode_next != DEV_POWER_DOWN) && (mode_next != DEV_SELF_REFRESH);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < NBANK; i++) begin
        st_reg[i]  <= BK_IDLE;
        cnt_reg[i] <= 4'h0;
      end
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_reg     <= DEV_NORMAL;
      dcnt_reg     <= 4'h0;
      cke_q_reg    <= 1'b1;
      input_buf_en <= 1'b1;
      illegal_cmd  <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      dcnt_reg     <= dcnt_next;
      cke_q_reg    <= cke;
      input_buf_en <= buf_en_next;
      illegal_cmd  <= illegal_next || illegal_gate;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wcol_reg      <= 8'h00;
      wbank_reg     <= 2'h0;
      mode_word_reg <= MODE_WORD_RST;
    end else begin
      wcol_reg      <= wcol_next;
      wbank_reg     <= wbank_next;
      mode_word_reg <= mode_word_next;
    end
  end

  assign bank_states = {st_reg[3], st_reg[2], st_reg[1], st_reg[0]};
  assign dev_mode    = mode_reg;
  assign mode_word   = mode_word_reg;

  store_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_store_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (store_ready),
    .in_data   ({push_bank, push_col, dq_in}),
    .out_valid (beat_valid),
    .out_ready (beat_ready),
    .out_data  (beat_data)
  );

  // checks
  logic open0;
  logic read_ac0;
  assign open0    = run && !cs_n && cmd == CMD_OPEN && ba == 2'h0 && st_reg[0] == BK_IDLE;
  assign read_ac0 = run && !cs_n && cmd == CMD_READ && addr[AUTO_CLOSE_BIT] && ba == 2'h0
                    && st_reg[0] == BK_ROW_ACTIVE;

  sequence s_open_run;
    open0 ##1 run [*2];
  endsequence
  sequence s_read_ac_run;
    read_ac0 ##1 run [*3];
  endsequence

  a_open_to_active: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_06]
    s_open_run |=> st_reg[0] == BK_ROW_ACTIVE) else $error("row not active after open delay");
  a_read_ac_close: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_14]
    s_read_ac_run |=> st_reg[0] == BK_PRECHARGING) else $error("auto-close read did not close");
  a_idle_read_illegal: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_03]
    (run && !cs_n && cmd == CMD_READ && st_reg[ba] == BK_IDLE) |=> illegal_cmd)
    else $error("read to idle bank not flagged");
  a_halt_stops: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_08]
    (run && !cs_n && cmd == CMD_HALT && st_reg[0] == BK_READ) |=> st_reg[0] == BK_ROW_ACTIVE)
    else $error("halt did not stop burst");
  a_self_entry: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_04]
    (run && all_idle && !cke && !cs_n && cmd == CMD_REF) |=> mode_reg == DEV_SELF_REFRESH
      && st_reg[0] == BK_IDLE) else $error("self refresh not entered");
  a_pd_buffers: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_05]
    (mode_reg == DEV_POWER_DOWN) |-> !input_buf_en) else $error("buffers on in power down");
  a_pd_exit: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_22]
    (mode_reg == DEV_POWER_DOWN && cke) |=> mode_reg == DEV_NORMAL)
    else $error("power down not left");
  a_suspend_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_24]
    (mode_reg == DEV_SUSPEND) |=> $stable(bank_states)) else $error("banks moved in suspend");
  a_self_exit: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_21]
    (mode_reg == DEV_SELF_REFRESH && cke && cs_n) |=> mode_reg == DEV_SELF_RECOV
      ##7 mode_reg == DEV_NORMAL) else $error("self refresh exit timing wrong");
endmodule : sdram_cmd_state

// file: sdram_cmd_pkg.sv
// constants, command codes and state types for the sdram command/state logic
// assumes a single 125 MHz clock; all timing counts are in cycles of it
package sdram_cmd_pkg;
  localparam int NBANK     = 4;
  localparam int CLK_NS    = 8;
  localparam int BURST_LEN = 4;
  // least times in ns, rounded up to whole cycles; write recovery is given in cycles
  localparam int T_RCD_NS  = 18;
  localparam int T_RP_NS   = 18;
  localparam int T_RC_NS   = 60;
  localparam int T_RSC_NS  = 12;
  localparam int T_DPL_TCK = 2;
  localparam logic [3:0] RCD_CYC = 4'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RP_CYC  = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RC_CYC  = 4'((T_RC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RSC_CYC = 4'((T_RSC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] DPL_CYC = 4'(T_DPL_TCK);
  localparam logic [3:0] BL_CYC  = 4'(BURST_LEN);
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int FIFO_DEPTH     = 16;
  localparam int FIFO_WIDTH     = 42;
  localparam logic [11:0] MODE_WORD_RST = 12'h000;
  // {row strobe, column strobe, write enable} with chip select low
  localparam logic [2:0] CMD_NOP   = 3'h7;
  localparam logic [2:0] CMD_HALT  = 3'h6;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_OPEN  = 3'h3;
  localparam logic [2:0] CMD_CLOSE = 3'h2;
  localparam logic [2:0] CMD_REF   = 3'h1;
  localparam logic [2:0] CMD_MODE  = 3'h0;

  typedef enum logic [3:0] {
    BK_IDLE        = 4'h0,
    BK_ACTIVATING  = 4'h1,
    BK_ROW_ACTIVE  = 4'h3,
    BK_READ        = 4'h2,
    BK_WRITE       = 4'h6,
    BK_WR_RECOV    = 4'h7,
    BK_PRECHARGING = 4'h5,
    BK_READ_AC     = 4'h4,
    BK_WRITE_AC    = 4'hC,
    BK_WR_RECOV_AC = 4'hD,
    BK_REFRESHING  = 4'hF,
    BK_MODE_ACCESS = 4'hE
  } bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL       = 3'h0,
    DEV_SUSPEND      = 3'h1,
    DEV_POWER_DOWN   = 3'h3,
    DEV_SELF_REFRESH = 3'h2,
    DEV_SELF_RECOV   = 3'h6
  } dev_mode_t;
endpackage : sdram_cmd_pkg

// file: store_fifo.sv
// first-in first-out buffer for write beats, flip-flop storage
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module store_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             full_reg;
  logic             empty_reg;
  logic             do_push;
  logic             do_pop;

  assign do_push   = in_valid && !full_reg;
  assign do_pop    = out_ready && !empty_reg;
  assign in_ready  = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (do_push && !do_pop) begin
      count_next = count_reg + 1'b1;
    end else if (do_pop && !do_push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      full_reg   <= 1'b0;
      empty_reg  <= 1'b1;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      full_reg  <= (count_next == FULL_CNT);
      empty_reg <= (count_next == '0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule : store_fifo

// file: ctrl_model.sv
// memory controller model: drives commands, clock gate and write data
// assumes the bench calls its tasks; pops beats unless stalled
`timescale 1ns/1ps
module ctrl_model
  import sdram_cmd_pkg::*;
(
  input  wire logic                  clk_sys,
  output logic                       cke,
  output logic                       cs_n,
  output logic                       ras_n,
  output logic                       cas_n,
  output logic                       we_n,
  output logic      [1:0]            ba,
  output logic      [11:0]           addr,
  output logic      [31:0]           dq_in,
  input  wire logic                  beat_valid,
  output logic                       beat_ready,
  input  wire logic [FIFO_WIDTH-1:0] beat_data
);
  logic [FIFO_WIDTH-1:0] got[$];
  logic                  stall;
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, stall} = 6'h3F;
    {ba, addr, dq_in} = '0;
  end
  assign beat_ready = !stall;
  always @(posedge clk_sys) begin
    if (beat_valid === 1'b1 && !stall) got.push_back(beat_data);
  end
  // deselected address lines show the inverse; a second call in a row, as in wr, brings back the stale value
  task automatic rel();
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= CMD_NOP;
    addr <= ~addr;
  endtask : rel
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic ck);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    cke <= ck;
    @(posedge clk_sys);
    rel();
  endtask : issue
  task automatic wr(input logic [1:0] b, input logic [7:0] col, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= CMD_WRITE;
    {ba, addr, dq_in} <= {b, 4'h0, col, d};
    // no close is sent inside a write burst or before the row-open minimum
    for (i = 1; i < 4; i++) begin
      @(posedge clk_sys);
      rel();
      dq_in <= d + 32'(i);
    end
    @(posedge clk_sys);
    dq_in <= ~dq_in;
  endtask : wr
  task automatic set_cke(input logic v);
    @(posedge clk_sys);
    cke <= v;
  endtask : set_cke
  task automatic set_stall(input logic v);
    @(posedge clk_sys);
    stall <= v;
  endtask : set_stall
endmodule : ctrl_model

// file: tb_sdram_cmd_state.sv
// bench for the sdram command/state block with a controller model
// assumes the package timing counts and the hand-over walks
`timescale 1ns/1ps
module tb_sdram_cmd_state;
  import sdram_cmd_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  cke, cs_n, ras_n, cas_n, we_n, beat_ready, beat_valid;
  logic                  illegal_cmd, input_buf_en, store_ready;
  logic [1:0]            ba;
  logic [11:0]           addr, mode_word;
  logic [31:0]           dq_in;
  logic [15:0]           bank_states;
  logic [2:0]            dev_mode;
  logic [FIFO_WIDTH-1:0] beat_data;
  logic [FIFO_WIDTH-1:0] exp_q[$];
  int                    n_fail = 0;
  int                    checks_done = 0;
  always #4 clk_sys = ~clk_sys;
  sdram_cmd_state u_sdram_cmd_state (.clk_sys(clk_sys), .sys_rst(sys_rst), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .dq_in(dq_in), .bank_states(bank_states), .dev_mode(dev_mode),
    .illegal_cmd(illegal_cmd), .input_buf_en(input_buf_en), .mode_word(mode_word),
    .store_ready(store_ready), .beat_valid(beat_valid), .beat_ready(beat_ready),
    .beat_data(beat_data));
  ctrl_model u_ctrl_model (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .beat_valid(beat_valid), .beat_ready(beat_ready), .beat_data(beat_data));
  task automatic fail(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk_state(input int b, input bank_state_t e);
    checks_done++;
    if (bank_states[b*4+:4] !== e) fail($sformatf("bank %0d state %h", b, bank_states[b*4+:4]));
  endtask : chk_state
  task automatic chk_dev(input dev_mode_t e);
    checks_done++;
    if (dev_mode !== e) fail($sformatf("device mode %h", dev_mode));
  endtask : chk_dev
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e) fail(m);
  endtask : chk_bit
  task automatic chk_vec(input logic [FIFO_WIDTH-1:0] g, input logic [FIFO_WIDTH-1:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("value %h wanted %h", g, e));
  endtask : chk_vec
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
    u_ctrl_model.issue(c, b, a, 1'b1);
    #1;
  endtask : cmd
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [31:0] d,
                    input bit keep);
    int i;
    for (i = 0; i < 4 && keep; i++) exp_q.push_back({b, c + 8'(i), d + 32'(i)});
    u_ctrl_model.wr(b, c, d);
    #1;
  endtask : wr
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic t_read();
    cmd(CMD_OPEN, 2'h0, 12'h123);
    chk_state(0, BK_ACTIVATING);
    cmd(CMD_READ, 2'h1, 12'h004);
    chk_bit(illegal_cmd, 1'b1, "no refusal");
    chk_state(1, BK_IDLE);
    cmd(CMD_READ, 2'h0, 12'h004);
    chk_state(0, BK_READ);
    step(2);
    chk_state(0, BK_READ);
    step(1);
    chk_state(0, BK_ROW_ACTIVE);
    $display("test read done");
  endtask : t_read
  task automatic t_burst_cut();
    cmd(CMD_READ, 2'h0, 12'h000);
    cmd(CMD_READ, 2'h0, 12'h008);
    step(2);
    chk_state(0, BK_READ);
    step(1);
    chk_state(0, BK_ROW_ACTIVE);
    cmd(CMD_READ, 2'h0, 12'h000);
    cmd(CMD_HALT, 2'h0, 12'h000);
    chk_state(0, BK_ROW_ACTIVE);
    cmd(CMD_READ, 2'h0, 12'h000);
    wr(2'h0, 8'h20, 32'hA5A50000, 1);
    chk_state(0, BK_WR_RECOV);
    step(1);
    chk_state(0, BK_ROW_ACTIVE);
    $display("test burst cut done");
  endtask : t_burst_cut
  task automatic t_fifo();
    int i;
    u_ctrl_model.set_stall(1'b1);
    for (i = 0; i < 4; i++) wr(2'h0, 8'(i * 16), 32'h1000 * i, 1);
    chk_bit(store_ready, 1'b0, "fifo not full");
    wr(2'h0, 8'hF0, 32'hDEAD0000, 0);
    u_ctrl_model.set_stall(1'b0);
    for (i = 0; i < 60 && beat_valid !== 1'b0; i++) step(1);
    if (i == 60) begin
      fail("drain timeout");
      print_verdict();
    end
    checks_done++;
    if (u_ctrl_model.got.size() != exp_q.size()) fail("beat count");
    for (i = 0; i < exp_q.size() && i < u_ctrl_model.got.size(); i++)
      chk_vec(u_ctrl_model.got[i], exp_q[i]);
    chk_bit(store_ready, 1'b1, "fifo full after drain");
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_auto_close();
    cmd(CMD_READ, 2'h0, 12'h410);
    chk_state(0, BK_READ_AC);
    cmd(CMD_CLOSE, 2'h0, 12'h000);
    chk_bit(illegal_cmd, 1'b1, "close not refused");
    step(1);
    chk_state(0, BK_PRECHARGING);
    step(2);
    chk_state(0, BK_IDLE);
    $display("test auto close done");
  endtask : t_auto_close
  task automatic t_refresh_mode();
    cmd(CMD_REF, 2'h0, 12'h000);
    chk_state(0, BK_REFRESHING);
    step(6);
    chk_state(3, BK_REFRESHING);
    step(1);
    chk_state(3, BK_IDLE);
    cmd(CMD_MODE, 2'h0, 12'h032);
    step(1);
    chk_vec(42'(mode_word), 42'h032);
    chk_state(0, BK_IDLE);
    $display("test refresh done");
  endtask : t_refresh_mode
  task automatic t_gate();
    u_ctrl_model.issue(CMD_REF, 2'h0, 12'h000, 1'b0);
    step(3);
    chk_dev(DEV_SELF_REFRESH);
    chk_bit(input_buf_en, 1'b0, "buffers on in self refresh");
    u_ctrl_model.set_cke(1'b1);
    step(1);
    chk_dev(DEV_SELF_RECOV);
    step(8);
    chk_dev(DEV_NORMAL);
    u_ctrl_model.set_cke(1'b0);
    step(3);
    chk_dev(DEV_POWER_DOWN);
    chk_bit(input_buf_en, 1'b0, "buffers on in power down");
    u_ctrl_model.set_cke(1'b1);
    step(1);
    chk_dev(DEV_NORMAL);
    chk_bit(input_buf_en, 1'b1, "buffers off after exit");
    u_ctrl_model.issue(CMD_OPEN, 2'h3, 12'h001, 1'b0);
    #1;
    chk_dev(DEV_SUSPEND);
    u_ctrl_model.set_cke(1'b1);
    step(1);
    chk_dev(DEV_NORMAL);
    chk_state(3, BK_ACTIVATING);
    $display("test clock gate done");
  endtask : t_gate
  initial begin
    step(4);
    sys_rst <= 1'b0;
    step(1);
    chk_vec(42'(bank_states), 42'h0);
    chk_dev(DEV_NORMAL);
    chk_bit(beat_valid, 1'b0, "fifo not empty at reset");
    chk_bit(input_buf_en & store_ready, 1'b1, "reset flags");
    u_ctrl_model.set_stall(1'b0);
    t_read();
    t_burst_cut();
    t_fifo();
    t_auto_close();
    t_refresh_mode();
    t_gate();
    print_verdict();
  end
endmodule : tb_sdram_cmd_state
